// [logic/rsc_top.sv]
// reset source control: gathers reset sources, keeps cause flags,
// gates the external reset pin through a key-committed setting
// assumes: resetn is the power-on reset; sources are asynchronous
//
// Register access over APB was decided locally.
`default_nettype none
`include "rsc_cfg.svh"

module rsc_top
   import rsc_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   input  wire logic                    ext_reset_pin_n,
   input  wire logic                    wdt_reset_req,
   input  wire logic                    clk_fault_reset_req,
   input  wire logic                    lvd1_reset_req,
   input  wire logic                    lvd2_reset_req,
   input  wire logic                    trim_fault_reset_req,
   input  wire logic                    flash_standby_reset_req,
   input  wire logic                    trim_abnormal,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`RSC_IDX_W+1:0]   paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic      [31:0]             prdata,
   output logic                         pslverr,
   output logic                         sys_reset_n,
   output logic                         ext_reset_disable_committed,
   output logic                         reserved_area_ctrl_committed,
   output logic                         reserved_vector_ctrl_committed,
   output logic                         irq
);

   // ************************************
   // declarations
   // ************************************
   rsc_state_s                s;
   rsc_state_s                next_s;
   logic [`RSC_SYNC_W-1:0]    raw_in;
   logic [`RSC_SYNC_W-1:0]    syn;
   logic [`RSC_IDX_W-1:0]     reg_idx;
   logic                      reg_wr;
   logic [7:0]                reg_wdata;
   logic [31:0]               rd_data;
   logic                      rd_hit;
   logic [`RSC_FLAG_W-1:0]    set_vec;
   logic                      int_any;
   logic                      pin_rst;
   logic                      rst_any;
   rsc_key_e                  key_act;

   // ************************************
   // functions
   // ************************************

   // key byte to commit action; unknown codes do nothing
   function automatic rsc_key_e key_decode(input logic wr, input logic [7:0] d);
      rsc_key_e k;
      k = RSC_KEY_NONE;
      if (wr) begin
         case (d)
            `RSC_KEY_PIN_DIS:  k = RSC_KEY_DIS;
            `RSC_KEY_AREA_VEC: k = RSC_KEY_AREA;
            `RSC_KEY_FLAG_CLR: k = RSC_KEY_CLR;
            default:           k = RSC_KEY_NONE;
         endcase
      end
      return k;
   endfunction : key_decode

   // write strobe for one register index
   function automatic logic wr_to(input logic wr, input logic [`RSC_IDX_W-1:0] i,
                                  input logic [`RSC_IDX_W-1:0] t);
      return wr && (i == t);
   endfunction : wr_to

   // read view of a register; unmapped reads give zero
   function automatic logic [32:0] rd_view(input logic [`RSC_IDX_W-1:0] i,
                                           input rsc_state_s st);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      case (i)
         `RSC_IDX_FLAGS:    r = {1'b1, 25'h0, st.flags};
         `RSC_IDX_CFG:      r = {1'b1, 29'h0, st.cfg};
         `RSC_IDX_KEY:      r = {1'b1, 29'h0, st.committed};
         `RSC_IDX_IRQ_STAT: r = {1'b1, 25'h0, st.irq_stat};
         `RSC_IDX_IRQ_MASK: r = {1'b1, 25'h0, st.irq_mask};
         default:           r = {1'b0, 32'h0000_0000};
      endcase
      return r;
   endfunction : rd_view

   // ************************************
   // input synchronisers
   // ************************************
   assign raw_in = {ext_reset_pin_n, trim_abnormal, flash_standby_reset_req,
                    trim_fault_reset_req, lvd2_reset_req, lvd1_reset_req,
                    clk_fault_reset_req, wdt_reset_req};

   rsc_sync #(
      .W    (`RSC_SYNC_W),
      .IDLE (`RSC_SYNC_IDLE)
   ) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .din      (raw_in),
      .dout     (syn)
   );

   // ************************************
   // apb front end
   // ************************************
   assign {rd_hit, rd_data} = rd_view(reg_idx, s);

   rsc_apb_slave u_apb (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .pstrb     (pstrb),
      .pready    (pready),
      .prdata    (prdata),
      .pslverr   (pslverr),
      .reg_idx   (reg_idx),
      .reg_wr    (reg_wr),
      .reg_wdata (reg_wdata),
      .rd_data   (rd_data),
      .rd_hit    (rd_hit)
   );

   // ************************************
   // reset sources
   // ************************************

   // flag set vector in cause register layout
   assign set_vec = {syn[5], syn[6], syn[4], syn[3], syn[2], syn[1], syn[0]};
   assign int_any = |syn[5:0];
   assign pin_rst = !syn[7] && !s.committed[`RSC_CFG_DIS_BIT];
   assign rst_any = int_any || pin_rst;
   assign key_act = key_decode(wr_to(reg_wr, reg_idx, `RSC_IDX_KEY), reg_wdata);

   // ************************************
   // next state
   // ************************************
   always_comb begin
      next_s = s;
      // written settings
      if (wr_to(reg_wr, reg_idx, `RSC_IDX_CFG)) begin
         next_s.cfg = reg_wdata[`RSC_CFG_W-1:0];
      end
      if (wr_to(reg_wr, reg_idx, `RSC_IDX_FLAGS)) begin
         next_s.clear_req = reg_wdata[`RSC_FLAG_CLR_BIT];
      end
      // key actions: commits into the shadow, or the requested flag clear
      case (key_act)
         RSC_KEY_DIS: begin
            next_s.committed[`RSC_CFG_DIS_BIT] = s.cfg[`RSC_CFG_DIS_BIT];
         end
         RSC_KEY_AREA: begin
            next_s.committed[`RSC_CFG_VEC_BIT:`RSC_CFG_AREA_BIT] =
               s.cfg[`RSC_CFG_VEC_BIT:`RSC_CFG_AREA_BIT];
         end
         RSC_KEY_CLR: begin
            if (s.clear_req) begin
               next_s.flags     = `RSC_FLAG_RST;
               next_s.clear_req = 1'b0;
            end
         end
         default: begin
         end
      endcase
      // pin reset clears flags, internal resets do not
      if (pin_rst) begin
         next_s.flags = `RSC_FLAG_RST;
      end
      // setting a flag wins over any clear
      next_s.flags = next_s.flags | set_vec;
      // any pin or internal reset drops the written values, never the shadow
      if (rst_any) begin
         next_s.cfg       = `RSC_CFG_RST;
         next_s.clear_req = 1'b0;
      end
      // interrupt status: write one to clear, new flags set
      if (wr_to(reg_wr, reg_idx, `RSC_IDX_IRQ_STAT)) begin
         next_s.irq_stat = s.irq_stat & ~reg_wdata[`RSC_FLAG_W-1:0];
      end
      next_s.irq_stat = next_s.irq_stat | (set_vec & ~s.flags);
      if (wr_to(reg_wr, reg_idx, `RSC_IDX_IRQ_MASK)) begin
         next_s.irq_mask = reg_wdata[`RSC_FLAG_W-1:0];
      end
      next_s.rst_out = rst_any;
   end

   // ************************************
   // state register; power-on clears all but rst_out, which it sets
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s <= '{cfg: `RSC_CFG_RST, committed: `RSC_CFG_RST, clear_req: 1'b0,
                flags: `RSC_FLAG_RST, irq_stat: `RSC_FLAG_RST,
                irq_mask: `RSC_MASK_RST, rst_out: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign sys_reset_n                    = !s.rst_out;
   assign ext_reset_disable_committed    = s.committed[`RSC_CFG_DIS_BIT];
   assign reserved_area_ctrl_committed   = s.committed[`RSC_CFG_AREA_BIT];
   assign reserved_vector_ctrl_committed = s.committed[`RSC_CFG_VEC_BIT];
   assign irq                            = |(s.irq_stat & s.irq_mask);

   // ************************************
   // assertions
   // ************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence seq_arm_clear;
      s.clear_req && !rst_any;
   endsequence

   sequence seq_key_clear;
      wr_to(reg_wr, reg_idx, `RSC_IDX_KEY) && reg_wdata == `RSC_KEY_FLAG_CLR;
   endsequence

   a_int_src_reset: assert property (int_any |=> !sys_reset_n)
      else $error("internal source did not assert system reset");

   a_pin_ignored: assert property (
      !syn[7] && ext_reset_disable_committed && !int_any |=> sys_reset_n)
      else $error("disabled pin still caused reset");

   a_shadow_only_key: assert property (
      $changed(ext_reset_disable_committed) |->
         $past(reg_wr) && $past(reg_idx) == `RSC_IDX_KEY &&
         $past(reg_wdata) == `RSC_KEY_PIN_DIS)
      else $error("committed disable changed without key");

   a_mismatch_keeps: assert property (
      key_act == RSC_KEY_NONE |=> $stable(s.committed))
      else $error("committed settings moved without matching key");

   a_area_commit: assert property (
      key_act == RSC_KEY_AREA |=>
         {reserved_vector_ctrl_committed, reserved_area_ctrl_committed} ==
         $past(s.cfg[`RSC_CFG_VEC_BIT:`RSC_CFG_AREA_BIT]))
      else $error("area and vector bits not committed");

   a_cfg_dropped: assert property (rst_any |=> s.cfg == `RSC_CFG_RST)
      else $error("written config survived a reset");

   // read checks watch the bus in the access cycle
   a_read_zero_bits: assert property (
      psel && penable && !pwrite && !pslverr && reg_idx != `RSC_IDX_IRQ_STAT &&
      reg_idx != `RSC_IDX_IRQ_MASK |-> prdata[31:7] == 25'h0 &&
      (reg_idx == `RSC_IDX_FLAGS || prdata[6:3] == 4'h0))
      else $error("reserved read bits not zero");

   a_status_view: assert property (
      psel && penable && !pwrite && !pslverr && reg_idx == `RSC_IDX_KEY |->
      prdata[0] == ext_reset_disable_committed)
      else $error("status does not show committed disable");

   a_wdt_flag: assert property (syn[0] |=> s.flags[`RSC_FLAG_WDT])
      else $error("watchdog flag not set");

   a_trim_status: assert property (syn[6] |=> s.flags[`RSC_FLAG_TRIM_ST])
      else $error("trim status not set");

   a_flags_kept: assert property (
      int_any && !pin_rst && key_act != RSC_KEY_CLR |=>
      (s.flags & $past(s.flags)) == $past(s.flags))
      else $error("internal reset cleared a flag");

   a_pin_clears: assert property (pin_rst |=> s.flags == $past(set_vec))
      else $error("pin reset did not clear flags");

   a_flag_clear: assert property (
      seq_arm_clear and seq_key_clear |=> s.flags == $past(set_vec) && !s.clear_req)
      else $error("committed clear did not clear flags");

   a_irq_level: assert property (
      (s.irq_stat & s.irq_mask) != 7'h00 |-> irq ##1 (irq || $past(reg_wr)))
      else $error("interrupt output wrong");

endmodule : rsc_top
`default_nettype wire

// [logic/rsc_cfg.svh]
// constants of the reset source control block: offsets, fields, codes
// assumes: included by bare name from the package and the modules
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// register indices; byte address is four times the index
`define RSC_IDX_W          12
`define RSC_IDX_FLAGS      12'hfcc
`define RSC_IDX_CFG        12'hfde
`define RSC_IDX_KEY        12'hfdf
`define RSC_IDX_IRQ_STAT   12'hfe0
`define RSC_IDX_IRQ_MASK   12'hfe1

// commit key codes
`define RSC_KEY_PIN_DIS    8'hb2
`define RSC_KEY_AREA_VEC   8'hd4
`define RSC_KEY_FLAG_CLR   8'h71

// field positions
`define RSC_CFG_DIS_BIT    0
`define RSC_CFG_AREA_BIT   1
`define RSC_CFG_VEC_BIT    2
`define RSC_CFG_W          3
`define RSC_FLAG_CLR_BIT   7
`define RSC_FLAG_W         7
`define RSC_FLAG_WDT       0
`define RSC_FLAG_CLK       1
`define RSC_FLAG_LVD1      2
`define RSC_FLAG_LVD2      3
`define RSC_FLAG_TRIM      4
`define RSC_FLAG_TRIM_ST   5
`define RSC_FLAG_FLASH     6

// reset values
`define RSC_CFG_RST        3'h0
`define RSC_FLAG_RST       7'h00
`define RSC_MASK_RST       7'h00

// synchroniser width and idle levels (pin reset idles high)
`define RSC_SYNC_W         8
`define RSC_SYNC_IDLE      8'h80

`endif

// [logic/rsc_pkg.sv]
// types of the reset source control block
// assumes: rsc_cfg.svh on the include path
`default_nettype none
`include "rsc_cfg.svh"

package rsc_pkg;

   // action selected by a write to the commit key
   typedef enum logic [1:0] {
      RSC_KEY_NONE,
      RSC_KEY_DIS,
      RSC_KEY_AREA,
      RSC_KEY_CLR
   } rsc_key_e;

   // complete state of the block
   typedef struct packed {
      logic [`RSC_CFG_W-1:0]  cfg;       // written, uncommitted settings
      logic [`RSC_CFG_W-1:0]  committed; // shadow that steers the logic
      logic                   clear_req; // written flag clear request
      logic [`RSC_FLAG_W-1:0] flags;     // reset cause flags
      logic [`RSC_FLAG_W-1:0] irq_stat;  // sticky event bits
      logic [`RSC_FLAG_W-1:0] irq_mask;  // interrupt enables
      logic                   rst_out;   // system reset asserted
   } rsc_state_s;

endpackage : rsc_pkg
`default_nettype wire

// [logic/rsc_sync.sv]
// two flip-flop synchroniser for asynchronous pins and fault requests
// assumes: one clock; idle value loaded on power-on reset
`default_nettype none
`include "rsc_cfg.svh"

module rsc_sync
   import rsc_pkg::*;
#(
   parameter int                  W    = 1,
   parameter logic [W-1:0]        IDLE = '0
) (
   input  wire logic          core_clk,
   input  wire logic          resetn,
   input  wire logic [W-1:0]  din,
   output logic      [W-1:0]  dout
);

   logic [W-1:0] meta;

   // ************************************
   // two stages, first read only by second
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         meta <= IDLE;
         dout <= IDLE;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : rsc_sync
`default_nettype wire

// [logic/rsc_apb_slave.sv]
// apb slave front end: decodes phases, registers read data and errors
// assumes: core gives read data and hit combinationally from the index
`default_nettype none
`include "rsc_cfg.svh"

module rsc_apb_slave
   import rsc_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`RSC_IDX_W+1:0]   paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic      [31:0]             prdata,
   output logic                         pslverr,
   output logic      [`RSC_IDX_W-1:0]   reg_idx,
   output logic                         reg_wr,
   output logic      [7:0]              reg_wdata,
   input  wire logic [31:0]             rd_data,
   input  wire logic                    rd_hit
);

   logic setup;
   logic hit_ok;

   // ************************************
   // decode
   // ************************************
   assign reg_idx   = paddr[`RSC_IDX_W+1:2];
   assign hit_ok    = rd_hit && (paddr[1:0] == 2'h0);
   assign setup     = psel && !penable;
   assign pready    = 1'b1; // no wait states
   assign reg_wr    = psel && penable && pwrite && pstrb[0] && !pslverr;
   assign reg_wdata = pwdata[7:0];

   // read data and error captured in setup, shown in access
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= (hit_ok && !pwrite) ? rd_data : 32'h0000_0000;
         pslverr <= !hit_ok;
      end
   end

endmodule : rsc_apb_slave
`default_nettype wire

// [verif/reset_source_control_tb_top.sv]
// self-checking bench of the reset source control block over apb
// assumes: rsc_pkg and rsc_top compiled first; one 50 mhz clock, no partner
`default_nettype none
`include "rsc_cfg.svh"

// compare one value, count it, report a mismatch at once
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", nm, (e), (g)); end end

module reset_source_control_tb_top
   import rsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [11:0] idx;
      logic        wr;
      logic [7:0]  wd;
      logic [31:0] exp;
      logic        err;
   } rsc_row_s;

   logic        core_clk, resetn, ext_reset_pin_n, trim_abnormal;
   logic        psel, penable, pwrite, pready, pslverr, sys_reset_n, irq;
   logic        dis_c, area_c, vec_c, err, rst_seen;
   logic [5:0]  src;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd, fexp;
   logic [3:0]  pstrb;
   int          mismatches, n_tests, cycles;
   int          fpos[6] = '{0, 1, 2, 3, 4, 6};

   // ****************************************
   // design and clock
   // ****************************************
   rsc_top dut (
      .core_clk                       (core_clk),
      .resetn                         (resetn),
      .ext_reset_pin_n                (ext_reset_pin_n),
      .wdt_reset_req                  (src[0]),
      .clk_fault_reset_req            (src[1]),
      .lvd1_reset_req                 (src[2]),
      .lvd2_reset_req                 (src[3]),
      .trim_fault_reset_req           (src[4]),
      .flash_standby_reset_req        (src[5]),
      .trim_abnormal                  (trim_abnormal),
      .psel                           (psel),
      .penable                        (penable),
      .pwrite                         (pwrite),
      .paddr                          (paddr),
      .pwdata                         (pwdata),
      .pstrb                          (pstrb),
      .pready                         (pready),
      .prdata                         (prdata),
      .pslverr                        (pslverr),
      .sys_reset_n                    (sys_reset_n),
      .ext_reset_disable_committed    (dis_c),
      .reserved_area_ctrl_committed   (area_c),
      .reserved_vector_ctrl_committed (vec_c),
      .irq                            (irq)
   );

   // free running clock, 20 ns period
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   // hang guard: counts a mismatch and closes the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   // prints the counts and the verdict, then ends the run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // one apb transfer; holds the request until pready at an edge
   task automatic apb_xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      // waits for the answer; only the hang guard ends a wait that never gets one
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb_xfer

   // reads one register and compares it
   task automatic rd_chk(input string nm, input logic [11:0] idx, input logic [31:0] e);
      apb_xfer(1'b0, idx, 32'h0);
      `CHK(nm, e, rd)
   endtask : rd_chk

   // holds one source active (6 = pin) and notes whether reset went low
   task automatic fire(input int s);
      @(posedge core_clk);
      if (s == 6) ext_reset_pin_n <= 1'b0;
      else src[s] <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst_seen = (sys_reset_n === 1'b0);
      ext_reset_pin_n <= 1'b1;
      src             <= 6'h00;
      do begin
         @(posedge core_clk);
      end while (sys_reset_n !== 1'b1);
   endtask : fire

   // ****************************************
   // ordinary cases: register table rows
   // ****************************************
   rsc_row_s rows[9] = '{
      '{`RSC_IDX_FLAGS,    1'b0, 8'h00, 32'h0, 1'b0},
      '{`RSC_IDX_CFG,      1'b0, 8'h00, 32'h0, 1'b0},
      '{`RSC_IDX_KEY,      1'b0, 8'h00, 32'h0, 1'b0},
      '{`RSC_IDX_IRQ_MASK, 1'b0, 8'h00, 32'h0, 1'b0},
      '{`RSC_IDX_CFG,      1'b1, 8'hff, 32'h7, 1'b0},
      '{`RSC_IDX_FLAGS,    1'b1, 8'h7f, 32'h0, 1'b0},
      '{`RSC_IDX_KEY,      1'b0, 8'h00, 32'h0, 1'b0},
      '{`RSC_IDX_KEY,      1'b1, 8'h55, 32'h0, 1'b0},
      '{12'h100,           1'b0, 8'h00, 32'h0, 1'b1}
   };

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {psel, penable, pwrite, trim_abnormal} = 4'h0;
      paddr = 14'h0; pwdata = 32'h0; pstrb = 4'h1; src = 6'h00;
      ext_reset_pin_n = 1'b1; resetn = 1'b0; fexp = 32'h0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      foreach (rows[i]) begin
         if (rows[i].wr) apb_xfer(1'b1, rows[i].idx, {24'h0, rows[i].wd});
         rd_chk("row data", rows[i].idx, rows[i].exp);
         `CHK("row error", rows[i].err, err)
      end
      // write with byte lane 0 off is ignored
      pstrb <= 4'h0;
      apb_xfer(1'b1, `RSC_IDX_CFG, 32'h0);
      pstrb <= 4'h1;
      rd_chk("lane off", `RSC_IDX_CFG, 32'h7);
      // commit by key codes, mismatched key keeps the shadow
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'hb2);
      rd_chk("status b2", `RSC_IDX_KEY, 32'h1);
      `CHK("area after b2", 1'b0, area_c)
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'hd4);
      rd_chk("status d4", `RSC_IDX_KEY, 32'h7);
      `CHK("vector bit", 1'b1, vec_c)
      apb_xfer(1'b1, `RSC_IDX_CFG, 32'h0);
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'h55);
      rd_chk("status kept", `RSC_IDX_KEY, 32'h7);
      `CHK("disable out", 1'b1, dis_c)
      // disabled pin is ignored
      fire(6);
      `CHK("pin ignored", 1'b0, rst_seen)
      // every internal source resets and leaves its flag
      apb_xfer(1'b1, `RSC_IDX_CFG, 32'h6);
      for (int s = 0; s < 6; s++) begin
         fire(s);
         `CHK("source reset", 1'b1, rst_seen)
         fexp[fpos[s]] = 1'b1;
         rd_chk("cause flags", `RSC_IDX_FLAGS, fexp);
      end
      rd_chk("written cfg", `RSC_IDX_CFG, 32'h0);
      rd_chk("committed kept", `RSC_IDX_KEY, 32'h7);
      @(posedge core_clk);
      trim_abnormal <= 1'b1;
      repeat (4) @(posedge core_clk);
      trim_abnormal <= 1'b0;
      fexp[5] = 1'b1;
      rd_chk("trim status", `RSC_IDX_FLAGS, fexp);
      // interrupt: raised, masked, cleared
      rd_chk("event bits", `RSC_IDX_IRQ_STAT, 32'h7f);
      `CHK("irq masked", 1'b0, irq)
      apb_xfer(1'b1, `RSC_IDX_IRQ_MASK, 32'h7f);
      @(posedge core_clk);
      `CHK("irq raised", 1'b1, irq)
      apb_xfer(1'b1, `RSC_IDX_IRQ_STAT, 32'h7f);
      @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      // clear code without a request does nothing, with one it clears
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'h71);
      rd_chk("no request", `RSC_IDX_FLAGS, 32'h7f);
      apb_xfer(1'b1, `RSC_IDX_FLAGS, 32'h80);
      rd_chk("request reads 0", `RSC_IDX_FLAGS, 32'h7f);
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'h71);
      rd_chk("flags cleared", `RSC_IDX_FLAGS, 32'h0);
      // flag set with no reset must survive a second clear code
      @(posedge core_clk);
      trim_abnormal <= 1'b1;
      repeat (4) @(posedge core_clk);
      trim_abnormal <= 1'b0;
      repeat (3) @(posedge core_clk);
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'h71);
      rd_chk("request gone", `RSC_IDX_FLAGS, 32'h20);
      // enabled pin resets, clears flags and written cfg, shadow stays
      apb_xfer(1'b1, `RSC_IDX_CFG, 32'h0);
      apb_xfer(1'b1, `RSC_IDX_KEY, 32'hb2);
      rd_chk("status enabled", `RSC_IDX_KEY, 32'h6);
      apb_xfer(1'b1, `RSC_IDX_CFG, 32'h5);
      fire(6);
      `CHK("pin reset", 1'b1, rst_seen)
      rd_chk("pin clears flags", `RSC_IDX_FLAGS, 32'h0);
      rd_chk("pin drops cfg", `RSC_IDX_CFG, 32'h0);
      rd_chk("shadow after pin", `RSC_IDX_KEY, 32'h6);
      // power-on reset clears the shadow
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK("reset held", 1'b0, sys_reset_n)
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      `CHK("reset out", 1'b1, sys_reset_n)
      rd_chk("shadow power-on", `RSC_IDX_KEY, 32'h0);
      `CHK("area power-on", 1'b0, area_c)
      finish_test();
   end

endmodule : reset_source_control_tb_top
`undef CHK
`default_nettype wire
